// *** src/wdpm_defines.vh ***
// Purpose: Constants for the watchdog, unlock and power-mode block.
// Assumes: Byte-wide special-function register port, one clock.
// Notes:   Offsets are the register addresses on that port.
`ifndef WDPM_DEFINES_VH
`define WDPM_DEFINES_VH
`define WDPM_ADDR_PWR_CTRL    8'h87
`define WDPM_ADDR_CLK_SEL     8'h8E
`define WDPM_ADDR_EXT_FLAGS   8'h91
`define WDPM_ADDR_UNLOCK      8'hC7
`define WDPM_ADDR_WDOG_CTRL   8'hD8
`define WDPM_ADDR_EXT_ENABLE  8'hE8
`define WDPM_UNLOCK_KEY1      8'hAA
`define WDPM_UNLOCK_KEY2      8'h55
`define WDPM_UNLOCK_CYCLES    2'h3
`define WDPM_WARN_CLOCKS      10'h200
`define WDPM_RING_CLOCKS      17'h10000
`define WDPM_CNT_W            27
`define WDPM_WDOG_VECTOR      8'h63
`define WDPM_BIT_IDLE         0
`define WDPM_BIT_STOP         1
`define WDPM_BIT_BANDGAP      0
`define WDPM_BIT_RING_SEL     1
`define WDPM_BIT_RING_MODE    2
`define WDPM_BIT_RESTART      0
`define WDPM_BIT_WD_EN        1
`define WDPM_BIT_WD_RSTF      2
`define WDPM_BIT_WD_IRQF      3
`define WDPM_BIT_POR          6
`define WDPM_BIT_IRQ_EN       4
`define WDPM_CLK_SEL_RESET    8'h00
`define WDPM_WDOG_CTRL_RESET  8'h00
`endif

// *** src/wdpm_top.v ***
// Functional notes
// - Early warning at 2^17/20/23/26 clocks.
// - Reset 512 clocks after warning unless restarted.
// - Interrupt flag sets 512 clocks before reset.
// - Watchdog reset sets reset-occurred flag.
// - Enable bit gates reset; unlock-only writable.
// - Unlocked restart clears count, new interval.
// - Interrupt request only when enable bit set.
// - Counter advances on every crystal clock outside stop.
// - AAh then 55h opens three-cycle window.
// - Protected writes ignored without fresh sequence.
// - Protected: bandgap, POR, enable, restart, flag.
// - Idle bit; any interrupt or reset exits (a watchdog reset here leaves idle_o high).
// - Stop bit halts clocks; external interrupt exits.
// - Bandgap bit keeps reference on in stop.
// - Ring select clocks wake from ring oscillator.
// - Switch to crystal after 65536 crystal clocks (here counted only in run mode, paused in idle).
// - Re-entering stop before switch stops ring.
// - Ring-mode status high while ring clocks.
//
// Purpose: Watchdog with unlock guard and idle/stop power-mode control.
// Assumes: Byte register port; crystal clock on sys_clk_i; reset clears all but mode_reg, which it loads with ST_RUN, and bandgap_on_o, which it sets.
// Notes:   Clock gating itself is outside; this block drives its controls.
`timescale 1ns/1ns
`default_nettype none
`include "wdpm_defines.vh"
module wdpm_top (
    input  wire       sys_clk_i,
    input  wire       rst_i,
    input  wire       wr_i,
    input  wire       rd_i,
    input  wire [7:0] addr_i,
    input  wire [7:0] wdata_i,
    input  wire       por_event_i,
    input  wire       any_irq_i,
    input  wire       ext_irq_i,
    input  wire       power_fail_irq_i,
    input  wire       xtal_ready_i,
    output reg  [7:0] rdata_o,
    output reg        rdata_valid_o,
    output reg        wdog_timeout_irq_o,
    output reg        wdog_cpu_reset_o,
    output reg        idle_o,
    output reg        stop_o,
    output reg        bandgap_on_o,
    output reg        ring_clk_sel_o
);
    //------------------------------------------------------------------
    // Register state
    //------------------------------------------------------------------
    localparam [2:0] ST_RUN  = 3'b001;
    localparam [2:0] ST_IDLE = 3'b010;
    localparam [2:0] ST_STOP = 3'b100;

    reg [2:0]               mode_reg;
    reg [7:0]               pwr_ctrl_reg;
    reg [7:0]               clk_sel_reg;
    reg [7:0]               ext_flags_reg;
    reg [7:0]               ext_enable_reg;
    reg                     wd_en_reg;
    reg                     wd_irqf_reg;
    reg                     wd_rstf_reg;
    reg                     por_flag_reg;
    reg [`WDPM_CNT_W-1:0]   count_reg;
    reg                     warned_reg;
    reg [9:0]               warn_cnt_reg;
    reg                     ring_mode_reg;
    reg [16:0]              ring_cnt_reg;
    reg                     stop_wake_reg;
    wire                    unlock_open;
    wire                    prot_wr;
    wire                    wr_wdog;
    wire                    wr_ext;
    wire                    restart;
    wire                    warn_hit;
    wire                    expire;

    // Return the warning point for a timeout select value.
    function [`WDPM_CNT_W-1:0] wdpm_limit;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    wdpm_limit = 27'h0020000;
                2'h1:    wdpm_limit = 27'h0100000;
                2'h2:    wdpm_limit = 27'h0800000;
                default: wdpm_limit = 27'h4000000;
            endcase
        end
    endfunction

    // Watchdog control readback layout.
    function [7:0] wdpm_wdog_view;
        input dummy;
        begin
            wdpm_wdog_view = 8'h00;
            wdpm_wdog_view[`WDPM_BIT_POR]      = por_flag_reg;
            wdpm_wdog_view[`WDPM_BIT_WD_IRQF]  = wd_irqf_reg;
            wdpm_wdog_view[`WDPM_BIT_WD_RSTF]  = wd_rstf_reg;
            wdpm_wdog_view[`WDPM_BIT_WD_EN]    = wd_en_reg;
        end
    endfunction

    //------------------------------------------------------------------
    // Unlock sequencer
    //------------------------------------------------------------------
    assign wr_wdog = wr_i && (addr_i == `WDPM_ADDR_WDOG_CTRL);
    assign wr_ext  = wr_i && (addr_i == `WDPM_ADDR_EXT_FLAGS);
    assign prot_wr = wr_wdog || wr_ext;

    wdpm_unlock u_unlock (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .wr_i      (wr_i),
        .addr_i    (addr_i),
        .wdata_i   (wdata_i),
        .prot_wr_i (prot_wr),
        .open_o    (unlock_open)
    );

    // Restart needs the window open; no clock prescaler is used.
    assign restart  = wr_wdog && unlock_open && wdata_i[`WDPM_BIT_RESTART];
    assign warn_hit = !warned_reg &&
                      (count_reg == wdpm_limit(clk_sel_reg[7:6]) - 27'h1);
    assign expire   = warned_reg && (warn_cnt_reg == `WDPM_WARN_CLOCKS - 10'h1);

    //------------------------------------------------------------------
    // Watchdog counter and flags
    //------------------------------------------------------------------
    // Counts every crystal clock outside stop; restart or processor reset clears it.
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_reg    <= {`WDPM_CNT_W{1'b0}};
            warned_reg   <= 1'b0;
            warn_cnt_reg <= 10'h000;
            wd_irqf_reg  <= 1'b0;
            wd_rstf_reg  <= 1'b0;
            wd_en_reg    <= 1'b0;
            por_flag_reg <= 1'b0;
            wdog_cpu_reset_o <= 1'b0;
        end else begin
            wdog_cpu_reset_o <= 1'b0;
            if (restart || wdog_cpu_reset_o) begin
                count_reg    <= {`WDPM_CNT_W{1'b0}};
                warned_reg   <= 1'b0;
                warn_cnt_reg <= 10'h000;
            end else if (mode_reg != ST_STOP) begin
                if (!warned_reg) begin
                    count_reg <= count_reg + 27'h1;
                    if (warn_hit) begin
                        warned_reg <= 1'b1;
                    end
                end else if (expire) begin
                    warned_reg   <= 1'b0;
                    warn_cnt_reg <= 10'h000;
                    count_reg    <= {`WDPM_CNT_W{1'b0}};
                    if (wd_en_reg) begin
                        wdog_cpu_reset_o <= 1'b1;
                    end
                end else begin
                    warn_cnt_reg <= warn_cnt_reg + 10'h1;
                end
            end
            // Protected bits change only inside the unlock window.
            if (wr_wdog && unlock_open) begin
                wd_en_reg    <= wdata_i[`WDPM_BIT_WD_EN];
                por_flag_reg <= wdata_i[`WDPM_BIT_POR];
                wd_irqf_reg  <= wdata_i[`WDPM_BIT_WD_IRQF];
            end
            if (wr_wdog) begin
                wd_rstf_reg <= wdata_i[`WDPM_BIT_WD_RSTF];
            end
            if (warn_hit && mode_reg != ST_STOP && !restart) begin
                wd_irqf_reg <= 1'b1;
            end
            if (expire && wd_en_reg && !restart) begin
                wd_rstf_reg <= 1'b1;
            end
            if (por_event_i) begin
                por_flag_reg <= 1'b1;
            end
        end
    end

    //------------------------------------------------------------------
    // Plain registers and interrupt request
    //------------------------------------------------------------------
    // Timeout select, interrupt enable and ext flag bits; only the bandgap bit needs unlock.
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            clk_sel_reg        <= `WDPM_CLK_SEL_RESET;
            ext_enable_reg     <= 8'h00;
            ext_flags_reg      <= 8'h00;
            wdog_timeout_irq_o <= 1'b0;
        end else begin
            if (wr_i && addr_i == `WDPM_ADDR_CLK_SEL) begin
                clk_sel_reg <= wdata_i;
            end
            if (wr_i && addr_i == `WDPM_ADDR_EXT_ENABLE) begin
                ext_enable_reg <= wdata_i;
            end
            if (wr_ext) begin
                ext_flags_reg[7:4]                <= wdata_i[7:4];
                ext_flags_reg[`WDPM_BIT_RING_SEL] <= wdata_i[`WDPM_BIT_RING_SEL];
                if (unlock_open) begin
                    ext_flags_reg[`WDPM_BIT_BANDGAP] <= wdata_i[`WDPM_BIT_BANDGAP];
                end
            end
            wdog_timeout_irq_o <= wd_irqf_reg && ext_enable_reg[`WDPM_BIT_IRQ_EN];
        end
    end

    //------------------------------------------------------------------
    // Power modes and ring oscillator hand-over
    //------------------------------------------------------------------
    // Idle and stop entry, wake-up and ring-to-crystal switching.
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_reg       <= ST_RUN;
            pwr_ctrl_reg   <= 8'h00;
            ring_mode_reg  <= 1'b0;
            ring_cnt_reg   <= 17'h00000;
            stop_wake_reg  <= 1'b0;
            idle_o         <= 1'b0;
            stop_o         <= 1'b0;
            bandgap_on_o   <= 1'b1;
            ring_clk_sel_o <= 1'b0;
        end else begin
            stop_wake_reg <= 1'b0;
            case (mode_reg)
                ST_RUN: begin
                    if (wr_i && addr_i == `WDPM_ADDR_PWR_CTRL) begin
                        pwr_ctrl_reg <= wdata_i;
                        if (wdata_i[`WDPM_BIT_STOP]) begin
                            mode_reg      <= ST_STOP;
                            ring_mode_reg <= 1'b0;
                        end else if (wdata_i[`WDPM_BIT_IDLE]) begin
                            mode_reg <= ST_IDLE;
                        end
                    end
                end
                ST_IDLE: begin
                    if (any_irq_i || wdog_timeout_irq_o) begin
                        mode_reg <= ST_RUN;
                        pwr_ctrl_reg[`WDPM_BIT_IDLE] <= 1'b0;
                    end
                end
                ST_STOP: begin
                    if (ext_irq_i || (ext_flags_reg[`WDPM_BIT_BANDGAP] && power_fail_irq_i)) begin
                        mode_reg      <= ST_RUN;
                        stop_wake_reg <= 1'b1;
                        pwr_ctrl_reg[`WDPM_BIT_STOP] <= 1'b0;
                        ring_mode_reg <= ext_flags_reg[`WDPM_BIT_RING_SEL];
                        ring_cnt_reg  <= 17'h00000;
                    end
                end
                default: begin
                    mode_reg <= ST_RUN;
                end
            endcase
            if (ring_mode_reg && mode_reg == ST_RUN && xtal_ready_i) begin
                if (ring_cnt_reg == `WDPM_RING_CLOCKS - 17'h1) begin
                    ring_mode_reg <= 1'b0;
                end else begin
                    ring_cnt_reg <= ring_cnt_reg + 17'h1;
                end
            end
            idle_o         <= (mode_reg == ST_IDLE);
            stop_o         <= (mode_reg == ST_STOP);
            bandgap_on_o   <= (mode_reg != ST_STOP) || ext_flags_reg[`WDPM_BIT_BANDGAP];
            ring_clk_sel_o <= ring_mode_reg;
        end
    end

    //------------------------------------------------------------------
    // Read port
    //------------------------------------------------------------------
    // Registered readback; unmapped addresses and the unlock port read 00h.
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o       <= 8'h00;
            rdata_valid_o <= 1'b0;
        end else begin
            rdata_valid_o <= rd_i;
            case (addr_i)
                `WDPM_ADDR_PWR_CTRL:   rdata_o <= pwr_ctrl_reg;
                `WDPM_ADDR_CLK_SEL:    rdata_o <= clk_sel_reg;
                `WDPM_ADDR_EXT_FLAGS:  rdata_o <= {ext_flags_reg[7:4], 1'b0,
                                                   ring_mode_reg,
                                                   ext_flags_reg[1:0]};
                `WDPM_ADDR_WDOG_CTRL:  rdata_o <= wdpm_wdog_view(1'b0);
                `WDPM_ADDR_EXT_ENABLE: rdata_o <= ext_enable_reg;
                default:               rdata_o <= 8'h00;
            endcase
        end
    end
endmodule // wdpm_top
`default_nettype wire

// *** src/wdpm_unlock.v ***
// Purpose: Two-byte unlock sequencer opening a short protected-write window.
// Assumes: One write strobe per cycle on the register port.
// Notes:   The window closes after its cycles or after one protected write.
`timescale 1ns/1ns
`default_nettype none
`include "wdpm_defines.vh"
module wdpm_unlock (
    input  wire       sys_clk_i,
    input  wire       rst_i,
    input  wire       wr_i,
    input  wire [7:0] addr_i,
    input  wire [7:0] wdata_i,
    input  wire       prot_wr_i,
    output wire       open_o
);
    reg       key1_reg;
    reg [1:0] win_reg;
    wire      ua_wr;

    assign ua_wr  = wr_i && (addr_i == `WDPM_ADDR_UNLOCK);
    assign open_o = (win_reg != 2'h0);

    // Track the key bytes and count the window down.
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            key1_reg <= 1'b0;
            win_reg  <= 2'h0;
        end else begin
            if (ua_wr) begin
                key1_reg <= (wdata_i == `WDPM_UNLOCK_KEY1);
                if (key1_reg && wdata_i == `WDPM_UNLOCK_KEY2) begin
                    win_reg <= `WDPM_UNLOCK_CYCLES;
                end else begin
                    win_reg <= 2'h0;
                end
            end else if (prot_wr_i && open_o) begin
                win_reg <= 2'h0;
            end else if (open_o) begin
                win_reg <= win_reg - 2'h1;
            end
            if (wr_i && !ua_wr) begin
                key1_reg <= 1'b0;
            end
        end
    end
endmodule // wdpm_unlock
`default_nettype wire

// *** testbench/tb_top.sv ***
// Purpose: Self-checking bench for the watchdog, unlock and power-mode block.
// Assumes: Inputs change on the falling edge; one 250 MHz clock.
// Notes:   One full watchdog interval is run, so the run is long.
`timescale 1ns/1ns
`default_nettype none
`include "wdpm_defines.vh"
module tb_top;
    logic       sys_clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic       por_event_i = 1'b0;
    logic       any_irq_i = 1'b0;
    logic       ext_irq_i = 1'b0;
    logic       power_fail_irq_i = 1'b0;
    logic       xtal_ready_i = 1'b1;
    logic [7:0] rdata_o;
    logic       rdata_valid_o, wdog_timeout_irq_o, wdog_cpu_reset_o;
    logic       idle_o, stop_o, bandgap_on_o, ring_clk_sel_o;
    int         err_total = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    int         i, t_wake, t_rs, t_ring, t_irq;
    logic [7:0] map_a [0:6] = '{8'h87, 8'h8E, 8'h91, 8'hC7, 8'hD8, 8'hE8, 8'h00};
    wdpm_top wdpm_top_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .wr_i(wr_i), .rd_i(rd_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .por_event_i(por_event_i), .any_irq_i(any_irq_i),
        .ext_irq_i(ext_irq_i), .power_fail_irq_i(power_fail_irq_i),
        .xtal_ready_i(xtal_ready_i), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
        .wdog_timeout_irq_o(wdog_timeout_irq_o), .wdog_cpu_reset_o(wdog_cpu_reset_o),
        .idle_o(idle_o), .stop_o(stop_o), .bandgap_on_o(bandgap_on_o),
        .ring_clk_sel_o(ring_clk_sel_o));
    // --------------------------------------------------------------
    // Clock, cycle count and bus tasks
    // --------------------------------------------------------------
    // The clock toggles every half period and a counter stamps events.
    always #2 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) cyc <= cyc + 1;
    // Compares one value and counts the outcome.
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        wr_i = 1'b1;
        addr_i = a;
        wdata_i = d;
        @(negedge sys_clk_i);
        wr_i = 1'b0;
    endtask
    // Reads a register, masks it and checks the answer in its valid cycle.
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(negedge sys_clk_i);
        rd_i = 1'b1;
        addr_i = a;
        @(negedge sys_clk_i);
        rd_i = 1'b0;
        chk("rdata_valid", rdata_valid_o, 1'b1);
        chk("rdata", rdata_o & m, e);
    endtask
    task automatic unlock;
        wr(8'hC7, 8'hAA);
        wr(8'hC7, 8'h55);
    endtask
    task automatic settle;
        repeat (3) @(negedge sys_clk_i);
    endtask
    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_reset;
        chk("bandgap_on", bandgap_on_o, 1'b1);
        for (i = 0; i < 7; i++) rd(map_a[i], 8'hFF, 8'h00);
    endtask
    // Protected bits move only right after a full, fresh key pair.
    task automatic t_unlock;
        @(negedge sys_clk_i);
        por_event_i = 1'b1;
        @(negedge sys_clk_i);
        por_event_i = 1'b0;
        wr(8'hD8, 8'h02);
        rd(8'hD8, 8'hFF, 8'h40);
        unlock();
        wr(8'hD8, 8'h02);
        rd(8'hD8, 8'hFF, 8'h02);
        wr(8'hD8, 8'h00);
        rd(8'hD8, 8'hFF, 8'h02);
        wr(8'hC7, 8'hAA);
        wr(8'hE8, 8'h00);
        wr(8'hC7, 8'h55);
        wr(8'hD8, 8'h00);
        rd(8'hD8, 8'hFF, 8'h02);
        unlock();
        repeat (5) @(negedge sys_clk_i);
        wr(8'hD8, 8'h00);
        rd(8'hD8, 8'hFF, 8'h02);
        unlock();
        wr(8'hD8, 8'h00);
        rd(8'hD8, 8'hFF, 8'h00);
    endtask
    // Idle and stop entry, wake sources and the bandgap control.
    task automatic t_power;
        wr(8'h87, 8'h01);
        settle();
        chk("idle", idle_o, 1'b1);
        any_irq_i = 1'b1;
        settle();
        any_irq_i = 1'b0;
        chk("idle_wake", idle_o, 1'b0);
        // Software restarts the watchdog after every idle wake.
        unlock();
        wr(8'hD8, 8'h01);
        wr(8'h87, 8'h02);
        settle();
        chk("stop", {stop_o, bandgap_on_o}, 2'b10);
        power_fail_irq_i = 1'b1;
        settle();
        power_fail_irq_i = 1'b0;
        chk("stop_pf_off", stop_o, 1'b1);
        ext_irq_i = 1'b1;
        settle();
        ext_irq_i = 1'b0;
        chk("stop_wake", stop_o, 1'b0);
        wr(8'h91, 8'h01);
        rd(8'h91, 8'h01, 8'h00);
        unlock();
        wr(8'h91, 8'h01);
        wr(8'h87, 8'h02);
        settle();
        chk("bandgap_stop", {stop_o, bandgap_on_o}, 2'b11);
        power_fail_irq_i = 1'b1;
        settle();
        power_fail_irq_i = 1'b0;
        chk("stop_pf_wake", stop_o, 1'b0);
    endtask
    // Ring wake, stop again, then one ring hand-over and one watchdog run.
    task automatic t_ring_wdog;
        wr(8'h91, 8'h03);
        wr(8'h87, 8'h02);
        settle();
        ext_irq_i = 1'b1;
        settle();
        ext_irq_i = 1'b0;
        chk("ring_on", ring_clk_sel_o, 1'b1);
        rd(8'h91, 8'h07, 8'h07);
        // No timed activity while the ring clocks; straight back to stop.
        wr(8'h87, 8'h02);
        settle();
        chk("ring_stop", {stop_o, ring_clk_sel_o}, 2'b10);
        ext_irq_i = 1'b1;
        settle();
        ext_irq_i = 1'b0;
        t_wake = cyc - 3;
        wr(8'hE8, 8'h10);
        unlock();
        wr(8'hD8, 8'h03);
        t_rs = cyc;
        t_ring = 0;
        t_irq = 0;
        for (i = 0; i < 32'h222E0 && wdog_cpu_reset_o !== 1'b1; i++) begin
            @(negedge sys_clk_i);
            if (t_ring == 0 && ring_clk_sel_o === 1'b0) t_ring = cyc;
            if (t_irq == 0 && wdog_timeout_irq_o === 1'b1) t_irq = cyc;
        end
        if (wdog_cpu_reset_o !== 1'b1) begin
            err_total++;
            results();
        end
        chk("ring_handover", t_ring - t_wake inside {[32'hFFFC:32'h10006]}, 1'b1);
        chk("warn_time", t_irq - t_rs inside {[32'h1FFFE:32'h20006]}, 1'b1);
        chk("reset_gap", cyc - t_irq, 32'h1FF);
        rd(8'hD8, 8'h0C, 8'h0C);
        unlock();
        wr(8'hD8, 8'h00);
        rd(8'hD8, 8'h08, 8'h00);
    endtask
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // --------------------------------------------------------------
    // Main sequence and hang limit
    // --------------------------------------------------------------
    initial begin
        repeat (8) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        rst_i = 1'b0;
        t_reset();
        t_unlock();
        t_power();
        t_ring_wdog();
        results();
    end
    initial begin
        #1000000;
        err_total++;
        results();
    end
endmodule // tb_top
bind wdpm_top wdpm_props wdpm_props_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .wr_i(wr_i),
    .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i), .any_irq_i(any_irq_i),
    .ext_irq_i(ext_irq_i), .power_fail_irq_i(power_fail_irq_i), .rdata_o(rdata_o),
    .rdata_valid_o(rdata_valid_o), .wdog_timeout_irq_o(wdog_timeout_irq_o),
    .wdog_cpu_reset_o(wdog_cpu_reset_o), .idle_o(idle_o), .stop_o(stop_o),
    .bandgap_on_o(bandgap_on_o), .ring_clk_sel_o(ring_clk_sel_o));
`default_nettype wire

// *** testbench/wdpm_props.sv ***
// Purpose: Port-level checks for the watchdog, unlock and power-mode block.
// Assumes: One crystal clock and an asynchronous active-high reset.
// Notes:   Bound to wdpm_top from the bench top file.
`timescale 1ns/1ns
`default_nettype none
`include "wdpm_defines.vh"
module wdpm_props (
    input wire logic       sys_clk_i,
    input wire logic       rst_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       any_irq_i,
    input wire logic       ext_irq_i,
    input wire logic       power_fail_irq_i,
    input wire logic [7:0] rdata_o,
    input wire logic       rdata_valid_o,
    input wire logic       wdog_timeout_irq_o,
    input wire logic       wdog_cpu_reset_o,
    input wire logic       idle_o,
    input wire logic       stop_o,
    input wire logic       bandgap_on_o,
    input wire logic       ring_clk_sel_o
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    // All checks run on the crystal clock and rest while reset is high.
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    a_read_answer: assert property (rd_i |=> rdata_valid_o)
        else $error("read strobe got no valid answer");
    a_unlock_reads: assert property (rd_i && addr_i == 8'hC7 |=> rdata_o == 8'h00)
        else $error("unlock register read back nonzero");
    a_reset_pulse: assert property (wdog_cpu_reset_o |=> !wdog_cpu_reset_o)
        else $error("watchdog reset longer than one cycle");
    a_mode_excl: assert property (!(idle_o && stop_o))
        else $error("idle and stop both active");
    a_bandgap_run: assert property (!stop_o |-> bandgap_on_o)
        else $error("reference off outside stop");
    a_stop_hold: assert property (stop_o && !ext_irq_i && !power_fail_irq_i |=> stop_o)
        else $error("stop ended without a wake source");
    a_idle_hold: assert property (idle_o && !any_irq_i && !wdog_timeout_irq_o
        && !wdog_cpu_reset_o |=> idle_o)
        else $error("idle ended without a wake source");
    a_ring_in_stop: assert property (stop_o && $past(stop_o) && $past(stop_o, 2)
        |-> !ring_clk_sel_o)
        else $error("ring clock selected during stop");
    a_stop_entry: assert property (wr_i && addr_i == 8'h87 && wdata_i == 8'h02 && !idle_o
        && !stop_o && !ext_irq_i && !power_fail_irq_i |-> ##[1:2] stop_o)
        else $error("stop not entered after write");
endmodule // wdpm_props
`default_nettype wire
